//--- verilog/qdac_pkg.sv
// constants and types for the quad converter write receiver
// assumes a two-wire bus master on the pins and straps held static
// What this block does
// R1 - a write opens with a start, then five fixed bits, two strap bits and a zero write bit.
// R2 - the control byte is 00, load select in 5:4, spare 3, channel in 2:1, data kind in 0.
// R3 - bit 0 of the control byte says whether power-down or conversion bytes follow.
// R4 - with data kind zero, high/low byte pairs are taken until a stop or repeated start.
// R5 - with data kind one, exactly two power-down bytes are taken, then stop or restart.
// R6 - the high byte holds conversion bits 9 to 2, most significant first.
// R7 - the low byte holds conversion bits 1 and 0 in bits 7 and 6, the rest ignored.
// R8 - the first power-down byte holds the two select bits in 7 and 6, the second is filler.
// R9 - the master should end each write with a repeated start to keep the bus.
// R10 - once addressed with a control byte, pairs keep coming under that same control.
// R11 - the device pulls data low in the ninth clock after a matching address and each byte, except bytes past the two power-down bytes.
// R12 - load 00 writes the temporary register, 01 also loads it out, 10 loads all, 11 broadcasts.
// R13 - a pair takes effect on the falling edge of the acknowledge clock after the low byte.
package qdac_pkg;
    localparam int NUM_CH = 4;
    localparam int DATA_W = 10;
    localparam int PD_W = 2;
    localparam int WORD_W = 12;
    localparam logic [4:0] ADDR_FIXED = 5'h13;
    localparam logic [3:0] BIT_ACK = 4'h8;
    localparam logic [3:0] BIT_ZERO = 4'h0;
    localparam logic [3:0] BIT_ONE = 4'h1;
    localparam int CTRL_KIND = 0;
    localparam int CTRL_CH_LO = 1;
    localparam int CTRL_CH_HI = 2;
    localparam int CTRL_LD_LO = 4;
    localparam int CTRL_LD_HI = 5;
    localparam int BYTE_TOP = 7;
    localparam int BYTE_NEXT = 6;
    localparam logic [1:0] LOAD_TEMP = 2'h0;
    localparam logic [1:0] LOAD_ONE = 2'h1;
    localparam logic [1:0] LOAD_ALL = 2'h2;
    localparam logic [1:0] LOAD_BCAST = 2'h3;
    localparam logic [1:0] PD_NORMAL = 2'h0;
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [WORD_W-1:0] WORD_RST = 12'h000;
    typedef enum {SEQ_ADDR, SEQ_CTRL, SEQ_HI, SEQ_LO, SEQ_PWR_SEL, SEQ_PWR_FILL, SEQ_IGN}
        qdac_seq_type;
endpackage

//--- verilog/qdac_link_if.sv
// signals between the bit receiver and the byte sequencer
// assumes both ends sit on the serial clock, resets come from the core clock
`timescale 1ns/10ps
`default_nettype none
interface qdac_link_if;
    logic [7:0] byteVal;
    logic ackClk;
    logic ackWant;
    logic sdaOe;
    logic frameRst;
    logic linkRst;
    modport bits (output byteVal, output ackClk, output sdaOe,
        input ackWant, input frameRst, input linkRst);
    modport seq (input byteVal, input ackClk, input sdaOe,
        output ackWant, output frameRst, output linkRst);
endinterface
`default_nettype wire

//--- verilog/qdac_cond_det.sv
// start and stop detection on the core clock
// assumes raw bus pins, asynchronous to mclk
`timescale 1ns/10ps
`default_nettype none
module qdac_cond_det (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic sclPin,
    input wire logic sdaPin,
    output logic sclHigh,
    output logic startDet,
    output logic stopDet
);
    import qdac_pkg::*;
    logic sclS1_q, sclS2_q, sclS3_q, sdaS1_q, sdaS2_q, sdaS3_q;
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            {sclS1_q, sclS2_q, sclS3_q} <= 3'h7;
            {sdaS1_q, sdaS2_q, sdaS3_q} <= 3'h7;
        end else begin
            {sclS1_q, sclS2_q, sclS3_q} <= {sclPin, sclS1_q, sclS2_q};
            {sdaS1_q, sdaS2_q, sdaS3_q} <= {sdaPin, sdaS1_q, sdaS2_q};
        end
    end
    assign sclHigh = sclS2_q;
    // R1 start condition
    assign startDet = sclS2_q & sclS3_q & sdaS3_q & ~sdaS2_q;
    // R4 stop condition
    assign stopDet = sclS2_q & sclS3_q & ~sdaS3_q & sdaS2_q;
endmodule
`default_nettype wire

//--- verilog/qdac_link_bits.sv
// bit shifter and acknowledge driver on the serial clock
// assumes data stable around rising serial clock edges
`timescale 1ns/10ps
`default_nettype none
module qdac_link_bits (
    input wire logic sclClk,
    input wire logic sdaIn,
    qdac_link_if.bits lnk
);
    import qdac_pkg::*;
    logic [3:0] bitCnt_q;
    logic [7:0] shift_q;
    logic sdaOe_q;
    always_ff @(posedge sclClk or posedge lnk.frameRst) begin
        if (lnk.frameRst) begin
            bitCnt_q <= BIT_ZERO;
            shift_q <= BYTE_RST;
        end else if (bitCnt_q == BIT_ACK) begin
            bitCnt_q <= BIT_ZERO;
        end else begin
            shift_q <= {shift_q[6:0], sdaIn};
            bitCnt_q <= bitCnt_q + BIT_ONE;
        end
    end
    // R11 ninth clock drive
    always_ff @(negedge sclClk or posedge lnk.frameRst) begin
        if (lnk.frameRst) begin
            sdaOe_q <= 1'b0;
        end else begin
            sdaOe_q <= (bitCnt_q == BIT_ACK) & lnk.ackWant;
        end
    end
    assign lnk.ackClk = (bitCnt_q == BIT_ACK);
    assign lnk.byteVal = shift_q;
    assign lnk.sdaOe = sdaOe_q;
endmodule
`default_nettype wire

//--- verilog/qdac_i2c_rx.sv
// write receiver top: byte sequencing, crossing, channel registers
// assumes sclClk is the bus clock pin, sdaIn the bus data pin
`timescale 1ns/10ps
`default_nettype none
module qdac_i2c_rx (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic sclClk,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    input wire logic addrPinHi,
    input wire logic addrPinLo,
    output logic [qdac_pkg::NUM_CH-1:0][qdac_pkg::DATA_W-1:0] dacCode,
    output logic [qdac_pkg::NUM_CH-1:0][qdac_pkg::PD_W-1:0] dacPowerdown,
    output logic [qdac_pkg::NUM_CH-1:0][qdac_pkg::WORD_W-1:0] tempWord,
    output logic updateStrobe,
    output logic frameActive
);
    import qdac_pkg::*;
    qdac_link_if lnk ();
    logic sclHigh, startDet, stopDet;
    qdac_cond_det condDet (
        .mclk(mclk),
        .resetn(resetn),
        .sclPin(sclClk),
        .sdaPin(sdaIn),
        .sclHigh(sclHigh),
        .startDet(startDet),
        .stopDet(stopDet)
    );
    qdac_link_bits linkBits (
        .sclClk(sclClk),
        .sdaIn(sdaIn),
        .lnk(lnk)
    );

    // core side resets for the link
    logic frameRst_q, linkRst_q, frameActive_q;
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            frameRst_q <= 1'b1;
            linkRst_q <= 1'b1;
            frameActive_q <= 1'b0;
        end else begin
            linkRst_q <= 1'b0;
            // R4 restart or stop ends the pairs
            frameRst_q <= startDet | stopDet | (frameRst_q & sclHigh);
            frameActive_q <= startDet | (frameActive_q & ~stopDet);
        end
    end
    assign lnk.frameRst = frameRst_q;
    assign lnk.linkRst = linkRst_q;

    // serial clock side: strap synchroniser
    logic [1:0] strapS1_q, strapS2_q;
    always_ff @(posedge sclClk or posedge lnk.linkRst) begin
        if (lnk.linkRst) begin
            strapS1_q <= 2'h0;
            strapS2_q <= 2'h0;
        end else begin
            strapS1_q <= {addrPinHi, addrPinLo};
            strapS2_q <= strapS1_q;
        end
    end

    // serial clock side: byte sequencer
    qdac_seq_type seq_q, seq_d;
    logic [7:0] ctrl_q, hi_q, pubCtrl_q, pubHi_q, pubLo_q;
    logic pubFlag_q, pubTgl_q;
    wire addrMatch = (lnk.byteVal[7:1] == {ADDR_FIXED, strapS2_q})
        & ~lnk.byteVal[0];
    wire ctrlKind = lnk.byteVal[CTRL_KIND];
    wire pairEnd = lnk.ackClk & ((seq_q == SEQ_LO) | (seq_q == SEQ_PWR_FILL));

    always_comb begin
        seq_d = seq_q;
        lnk.ackWant = 1'b1;
        case (seq_q)
            SEQ_ADDR: begin
                // R1 address and write bit
                lnk.ackWant = addrMatch;
                seq_d = addrMatch ? SEQ_CTRL : SEQ_IGN;
            end
            SEQ_CTRL: begin
                // R3 data kind decides path
                seq_d = ctrlKind ? SEQ_PWR_SEL : SEQ_HI;
            end
            SEQ_HI: seq_d = SEQ_LO;
            // R10 pairs repeat on one control
            SEQ_LO: seq_d = SEQ_HI;
            SEQ_PWR_SEL: seq_d = SEQ_PWR_FILL;
            // R5 only two power-down bytes
            SEQ_PWR_FILL: seq_d = SEQ_IGN;
            SEQ_IGN: lnk.ackWant = 1'b0;
            default: begin
                lnk.ackWant = 1'b0;
                seq_d = SEQ_IGN;
            end
        endcase
    end

    always_ff @(posedge sclClk or posedge frameRst_q) begin
        if (frameRst_q) begin
            seq_q <= SEQ_ADDR;
            ctrl_q <= BYTE_RST;
            hi_q <= BYTE_RST;
            pubFlag_q <= 1'b0;
        end else begin
            pubFlag_q <= pairEnd;
            if (lnk.ackClk) begin
                seq_q <= seq_d;
            end
            if (lnk.ackClk && seq_q == SEQ_CTRL) begin
                ctrl_q <= lnk.byteVal;
            end
            if (lnk.ackClk && (seq_q == SEQ_HI || seq_q == SEQ_PWR_SEL)) begin
                hi_q <= lnk.byteVal;
            end
        end
    end

    // published pair, held until the next pair
    always_ff @(posedge sclClk or posedge linkRst_q) begin
        if (linkRst_q) begin
            pubCtrl_q <= BYTE_RST;
            pubHi_q <= BYTE_RST;
            pubLo_q <= BYTE_RST;
        end else if (pairEnd) begin
            pubCtrl_q <= ctrl_q;
            pubHi_q <= hi_q;
            pubLo_q <= lnk.byteVal;
        end
    end

    // R13 falling edge of acknowledge clock
    always_ff @(negedge sclClk or posedge linkRst_q) begin
        if (linkRst_q) begin
            pubTgl_q <= 1'b0;
        end else begin
            pubTgl_q <= pubTgl_q ^ pubFlag_q;
        end
    end

    // core side: toggle synchroniser
    logic pubS1_q, pubS2_q, pubS3_q;
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            {pubS1_q, pubS2_q, pubS3_q} <= 3'h0;
        end else begin
            {pubS1_q, pubS2_q, pubS3_q} <= {pubTgl_q, pubS1_q, pubS2_q};
        end
    end
    wire pairEvt = pubS2_q ^ pubS3_q;

    // R2 control field split
    wire [1:0] loadSel = pubCtrl_q[CTRL_LD_HI:CTRL_LD_LO];
    wire [1:0] chSel = pubCtrl_q[CTRL_CH_HI:CTRL_CH_LO];
    wire isPd = pubCtrl_q[CTRL_KIND];
    wire isBcast = (loadSel == LOAD_BCAST);
    wire bcastNew = isBcast & pubCtrl_q[CTRL_CH_HI];
    // R6 high byte bits 9 to 2
    // R7 low byte bits 1 and 0 only
    wire [DATA_W-1:0] dataVal = {pubHi_q, pubLo_q[BYTE_TOP:BYTE_NEXT]};
    // R8 select bits in top of first byte
    wire [PD_W-1:0] pdVal = pubHi_q[BYTE_TOP:BYTE_NEXT];

    logic [NUM_CH-1:0][WORD_W-1:0] temp_q, temp_d, out_q, out_d;
    genvar ch;
    generate
        for (ch = 0; ch < NUM_CH; ch = ch + 1) begin : gChan
            wire selMe = (chSel == 2'(ch));
            wire [WORD_W-1:0] chanWord = isPd ? {pdVal, temp_q[ch][DATA_W-1:0]}
                : {PD_NORMAL, dataVal};
            // R12 load select targets
            wire writeT = pairEvt & ((~isBcast & selMe) | bcastNew);
            wire loadO = pairEvt & (((loadSel == LOAD_ONE) & selMe)
                | (loadSel == LOAD_ALL) | isBcast);
            wire [WORD_W-1:0] nextTemp = writeT ? chanWord : temp_q[ch];
            assign temp_d[ch] = nextTemp;
            assign out_d[ch] = loadO ? nextTemp : out_q[ch];
            assign dacCode[ch] = out_q[ch][DATA_W-1:0];
            assign dacPowerdown[ch] = out_q[ch][WORD_W-1:DATA_W];
        end
    endgenerate

    logic updateStrobe_q;
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            temp_q <= {NUM_CH{WORD_RST}};
            out_q <= {NUM_CH{WORD_RST}};
            updateStrobe_q <= 1'b0;
        end else begin
            temp_q <= temp_d;
            out_q <= out_d;
            updateStrobe_q <= pairEvt;
        end
    end

    assign tempWord = temp_q;
    assign updateStrobe = updateStrobe_q;
    assign frameActive = frameActive_q;
    assign sdaOut = 1'b0;
    assign sdaOe = lnk.sdaOe;
endmodule
`default_nettype wire

//--- verification/qdac_i2c_rx_sva.sv
// assertions on the receiver top ports
// assumes mclk core clock and the serial clock on sclClk
`timescale 1ns/10ps
`default_nettype none
module qdac_i2c_rx_sva (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic sclClk,
    input wire logic sdaOut,
    input wire logic sdaOe,
    input wire logic [qdac_pkg::NUM_CH-1:0][qdac_pkg::DATA_W-1:0] dacCode,
    input wire logic [qdac_pkg::NUM_CH-1:0][qdac_pkg::PD_W-1:0] dacPowerdown,
    input wire logic [qdac_pkg::NUM_CH-1:0][qdac_pkg::WORD_W-1:0] tempWord,
    input wire logic updateStrobe,
    input wire logic frameActive
);
    import qdac_pkg::*;
    chk_sda_low: assert property (@(posedge mclk) disable iff (!resetn)
        sdaOut == 1'b0) else $error("data pin driven high");
    chk_ack_period: assert property (@(negedge sclClk) disable iff (!resetn)
        $rose(sdaOe) |=> $fell(sdaOe)) else $error("ack not one bit long");
    chk_idle_no_ack: assert property (@(posedge mclk) disable iff (!resetn)
        !frameActive |-> !sdaOe) else $error("ack outside frame");
    chk_strobe_single: assert property (@(posedge mclk) disable iff (!resetn)
        updateStrobe |=> !updateStrobe) else $error("strobe too long");
    chk_temp_strobe: assert property (@(posedge mclk) disable iff (!resetn)
        !$stable(tempWord) |-> updateStrobe) else $error("temp change without strobe");
    chk_code_strobe: assert property (@(posedge mclk) disable iff (!resetn)
        !$stable(dacCode) |-> updateStrobe) else $error("code change without strobe");
    chk_pd_strobe: assert property (@(posedge mclk) disable iff (!resetn)
        !$stable(dacPowerdown) |-> updateStrobe) else $error("pd change without strobe");
    chk_strobe_frame: assert property (@(posedge mclk) disable iff (!resetn)
        updateStrobe |-> frameActive) else $error("update outside frame");
    chk_reset_clear: assert property (@(posedge mclk)
        !resetn |=> dacCode == '0 && !updateStrobe) else $error("reset not clearing");
    cover property (@(posedge mclk) updateStrobe);
    cover property (@(posedge mclk) $fell(frameActive));
    cover property (@(posedge mclk) dacPowerdown != '0);
endmodule
bind qdac_i2c_rx qdac_i2c_rx_sva i_qdac_i2c_rx_sva (.mclk, .resetn, .sclClk, .sdaOut, .sdaOe,
    .dacCode, .dacPowerdown, .tempWord, .updateStrobe, .frameActive);
`default_nettype wire

//--- verification/qdac_bus_master.sv
// two-wire bus master model
// assumes the bench resolves the open-drain data wire with a pull-up
`timescale 1ns/10ps
`default_nettype none
module qdac_bus_master (
    output logic scl,
    output logic sdaDrv,
    input wire logic sdaBus
);
    localparam real QTR = 31.25;
    initial begin
        scl = 1'b1;
        sdaDrv = 1'b1;
    end
    task automatic start();
        sdaDrv = 1'b1;
        #QTR scl = 1'b1;
        #(2*QTR) sdaDrv = 1'b0;
        #(2*QTR) scl = 1'b0;
        #QTR;
    endtask
    task automatic bitOut(input logic b);
        sdaDrv = b;
        #QTR scl = 1'b1;
        #(2*QTR) scl = 1'b0;
        #QTR;
    endtask
    task automatic wrByte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) bitOut(b[i]);
        sdaDrv = 1'b1;
        #QTR scl = 1'b1;
        #QTR ack = !sdaBus;
        #QTR scl = 1'b0;
        #QTR;
    endtask
    task automatic stop();
        sdaDrv = 1'b0;
        #QTR scl = 1'b1;
        #(2*QTR) sdaDrv = 1'b1;
        #(2*QTR);
    endtask
endmodule
`default_nettype wire

//--- verification/tb.sv
// self-checking bench for the write receiver
// assumes the master model as the only bus partner
`timescale 1ns/10ps
`default_nettype none
module tb;
    import qdac_pkg::*;
    localparam logic [7:0] ADDR_W = {ADDR_FIXED, 3'h4};
    logic mclk, resetn, scl, sdaDrv, addrPinHi, addrPinLo;
    logic sdaOut, sdaOe, updateStrobe, frameActive;
    logic [NUM_CH-1:0][DATA_W-1:0] dacCode;
    logic [NUM_CH-1:0][PD_W-1:0] dacPowerdown;
    logic [NUM_CH-1:0][WORD_W-1:0] tempWord;
    int n_mismatch = 0;
    int checks_done = 0;
    int nStrobe = 0;
    wire sdaBus = sdaDrv & (sdaOe ? sdaOut : 1'b1);
    qdac_i2c_rx i_qdac_i2c_rx (.mclk(mclk), .resetn(resetn), .sclClk(scl), .sdaIn(sdaBus),
        .sdaOut(sdaOut), .sdaOe(sdaOe), .addrPinHi(addrPinHi), .addrPinLo(addrPinLo),
        .dacCode(dacCode), .dacPowerdown(dacPowerdown), .tempWord(tempWord),
        .updateStrobe(updateStrobe), .frameActive(frameActive));
    qdac_bus_master i_qdac_bus_master (.scl(scl), .sdaDrv(sdaDrv), .sdaBus(sdaBus));
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    always @(posedge mclk) if (updateStrobe === 1'b1) nStrobe <= nStrobe + 1;
    task automatic stop_test();
        $display("mismatches %0d checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic check(input logic [47:0] seen, input logic [47:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wb(input logic [7:0] b, input logic expAck);
        logic ack;
        i_qdac_bus_master.wrByte(b, ack);
        check(48'(ack), 48'(expAck));
    endtask
    task automatic hdr(input logic [7:0] ctrl);
        i_qdac_bus_master.start();
        wb(ADDR_W, 1'b1);
        wb(ctrl, 1'b1);
    endtask
    task automatic endFrame();
        i_qdac_bus_master.stop();
        repeat (6) @(negedge mclk);
    endtask
    task automatic t_data();
        hdr(8'h02);
        check(48'(frameActive), 48'h1);
        wb(8'hA5, 1'b1);
        wb(8'hC0, 1'b1);
        repeat (6) @(negedge mclk);
        check(48'(tempWord[1]), 48'h297);
        wb(8'h3C, 1'b1);
        wb(8'h7F, 1'b1);
        endFrame();
        hdr(8'h02);
        wb(8'h11, 1'b1);
        endFrame();
        check(tempWord, {12'h0, 12'h0, 12'h0F1, 12'h0});
        check(48'(dacCode), 48'h0);
        check(48'(nStrobe), 48'h2);
        check(48'(frameActive), 48'h0);
    endtask
    task automatic t_load();
        hdr(8'h14);
        wb(8'hFF, 1'b1);
        wb(8'hC0, 1'b1);
        hdr(8'h26);
        wb(8'h01, 1'b1);
        wb(8'h00, 1'b1);
        endFrame();
        check(tempWord, {12'h004, 12'h3FF, 12'h0F1, 12'h0});
        check(48'(dacCode), 48'({10'h004, 10'h3FF, 10'h0F1, 10'h0}));
    endtask
    task automatic t_pd();
        hdr(8'h11);
        wb(8'h80, 1'b1);
        wb(8'h00, 1'b1);
        wb(8'h00, 1'b0);
        endFrame();
        check(48'(dacPowerdown), 48'h02);
        check(48'(tempWord[0]), 48'h800);
        check(48'(dacCode[0]), 48'h0);
    endtask
    task automatic t_bad();
        for (int i = 0; i < 2; i++) begin
            i_qdac_bus_master.start();
            wb(i == 0 ? ADDR_W ^ 8'h02 : ADDR_W | 8'h01, 1'b0);
            wb(8'h02, 1'b0);
            endFrame();
        end
        check(48'(nStrobe), 48'h5);
    endtask
    task automatic t_bcast();
        hdr(8'h34);
        wb(8'h80, 1'b1);
        wb(8'h00, 1'b1);
        endFrame();
        check(tempWord, {4{12'h200}});
        check(48'(dacCode), 48'({4{10'h200}}));
        check(48'(dacPowerdown), 48'h0);
        hdr(8'h06);
        wb(8'hFF, 1'b1);
        wb(8'h40, 1'b1);
        hdr(8'h30);
        wb(8'h00, 1'b1);
        wb(8'h00, 1'b1);
        endFrame();
        check(tempWord, {12'h3FD, {3{12'h200}}});
        check(48'(dacCode), 48'({10'h3FD, {3{10'h200}}}));
        hdr(8'h35);
        wb(8'hC0, 1'b1);
        wb(8'h00, 1'b1);
        endFrame();
        check(tempWord, {12'hFFD, {3{12'hE00}}});
        check(48'(dacPowerdown), 48'hFF);
        check(48'(dacCode), 48'({10'h3FD, {3{10'h200}}}));
    endtask
    initial begin
        resetn = 1'b0;
        addrPinHi = 1'b1;
        addrPinLo = 1'b0;
        repeat (5) @(negedge mclk);
        resetn = 1'b1;
        repeat (6) @(negedge mclk);
        check(48'(dacCode), 48'h0);
        t_data();
        t_load();
        t_pd();
        t_bad();
        t_bcast();
        stop_test();
    end
    initial begin
        #400000;
        n_mismatch++;
        stop_test();
    end
endmodule
`default_nettype wire
